// [core/swah_top.sv]
/*
 * switch array host port: parallel bus, serial port, flags.
 * assumes a 200 MHz core clock and a host shift clock.
 */
`include "swah_map.svh"
`timescale 1ns/1ps
`default_nettype none
module swah_top #(
    parameter int unsigned RST_HOLD_CYC = `SWAH_RST_HOLD_CYC,
    parameter int unsigned STARTUP_CYC = `SWAH_STARTUP_CYC,
    parameter int unsigned DIRECT_CYC = `SWAH_DIRECT_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic interface_sel,
    input wire logic output_kill_n,
    input wire logic output_sync,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic ale,
    input wire logic serial_format_sel1,
    input wire logic [7:0] mux_bus,
    input wire logic supply_fault,
    input wire logic link_fault,
    input wire logic [7:0] chan_fault,
    output logic [7:0] switch_outputs,
    output logic [7:0] mux_bus_out,
    output logic [7:0] mux_bus_oe,
    output logic wr_n_out,
    output logic wr_n_oe,
    output logic ale_out,
    output logic ale_oe,
    output logic serial_out,
    output logic serial_out_oe,
    output logic fault_n_out,
    output logic fault_n_oe,
    output logic check_fail_n,
    output logic check_fail_n_oe,
    output logic serial_mode
);
    import swah_pkg::*;

    localparam int HW = $clog2(RST_HOLD_CYC + 1);
    localparam int SW = $clog2(STARTUP_CYC + 1);
    localparam int DW = $clog2(DIRECT_CYC + 1);
    localparam logic [4:0] FAST_INIT = 5'h1e;

    // filtered pins
    logic [4:0] fast_lvl;
    logic [2:0] slow_lvl;
    logic kill_lvl;
    logic [4:0] fast_pin;
    logic [2:0] slow_pin;
    assign fast_pin = {output_sync, cs_n, wr_n, rd_n, ale};
    assign slow_pin = {interface_sel, rd_n, serial_format_sel1};

    for (genvar gi = 0; gi < 5; gi++) begin : g_fast
        swah_blank #(
            .CYC(`SWAH_BLANK_FAST_CYC),
            .INIT(FAST_INIT[gi])
        ) u_blank (
            .mclk(mclk),
            .rstn(rstn),
            .pin(fast_pin[gi]),
            .level(fast_lvl[gi])
        );
    end

    for (genvar gi = 0; gi < 3; gi++) begin : g_slow
        swah_blank #(
            .CYC(`SWAH_BLANK_SLOW_CYC),
            .INIT(1'b0)
        ) u_blank (
            .mclk(mclk),
            .rstn(rstn),
            .pin(slow_pin[gi]),
            .level(slow_lvl[gi])
        );
    end

    swah_blank #(
        .CYC(1),
        .INIT(1'b0)
    ) u_kill (
        .mclk(mclk),
        .rstn(rstn),
        .pin(output_kill_n),
        .level(kill_lvl)
    );

    wire sync_f = fast_lvl[4];
    wire cs_f = fast_lvl[3];
    wire wr_f = fast_lvl[2];
    wire rd_f = fast_lvl[1];
    wire ale_f = fast_lvl[0];
    wire sel_f = slow_lvl[2];
    wire ms0_f = slow_lvl[1];
    wire ms1_f = slow_lvl[0];
    wire kill = !kill_lvl;

    logic [17:0] in_s1_q;
    logic [17:0] in_s2_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            in_s1_q <= '0;
            in_s2_q <= '0;
        end else begin
            in_s1_q <= {supply_fault, link_fault, chan_fault, mux_bus};
            in_s2_q <= in_s1_q;
        end
    end
    wire [7:0] bus_s = in_s2_q[7:0];
    wire [7:0] chf_s = in_s2_q[15:8];
    wire fault_any = in_s2_q[17] | in_s2_q[16] | (|chf_s);

    // edge history
    logic cs_prev_q;
    logic wr_prev_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cs_prev_q <= 1'b1;
            wr_prev_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_f;
            wr_prev_q <= wr_f;
        end
    end
    wire cs_rise = cs_f && !cs_prev_q;
    wire wr_rise = wr_f && !wr_prev_q;

    // reset by hold of chip select and latch
    logic [HW-1:0] hold_q;
    wire hold_cond = !cs_f && ale_f;
    wire soft_rst = hold_cond && (hold_q == HW'(RST_HOLD_CYC - 1));
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hold_q <= '0;
        end else if (!hold_cond) begin
            hold_q <= '0;
        end else if (hold_q != HW'(RST_HOLD_CYC)) begin
            hold_q <= hold_q + 1'b1;
        end
    end

    // interface mode machine
    swah_state_t state_q;
    swah_state_t state_d;
    logic [SW-1:0] st_cnt_q;
    logic [DW-1:0] dir_cnt_q;
    wire st_done = (st_cnt_q == SW'(STARTUP_CYC - 1));
    wire direct_pins = !cs_f && !wr_f && !ale_f && rd_f;
    wire direct_hold = (dir_cnt_q == DW'(DIRECT_CYC - 1));
    wire par_mode = (state_q == swah_start) || (state_q == swah_par);
    wire ser_mode = (state_q == swah_ser);

    always_comb begin
        state_d = state_q;
        case (state_q)
            swah_start: begin
                if (st_done) begin
                    state_d = sel_f ? swah_ser : swah_par;
                end
            end
            swah_par: begin
                if (sel_f) begin
                    state_d = swah_ser;
                end else if (direct_hold) begin
                    state_d = swah_direct;
                end
            end
            swah_direct: begin
                if (sel_f) begin
                    state_d = swah_ser;
                end else if (!direct_pins) begin
                    state_d = swah_par;
                end
            end
            swah_ser: begin
                if (!sel_f) begin
                    state_d = swah_par;
                end
            end
            default: state_d = swah_start;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= swah_start;
            st_cnt_q <= '0;
        end else if (soft_rst) begin
            state_q <= swah_start;
            st_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == swah_start && !st_done) begin
                st_cnt_q <= st_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dir_cnt_q <= '0;
        end else if (state_q != swah_par || !direct_pins) begin
            dir_cnt_q <= '0;
        end else if (!direct_hold) begin
            dir_cnt_q <= dir_cnt_q + 1'b1;
        end
    end

    // address latch while latch input high
    logic [7:0] addr_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            addr_q <= `SWAH_ADDR_RST;
        end else if (soft_rst) begin
            addr_q <= `SWAH_ADDR_RST;
        end else if (par_mode && !cs_f && ale_f) begin
            addr_q <= bus_s;
        end
    end

    // write on strobe rising edge, top bit one
    wire par_wr = par_mode && !cs_f && !ale_f && wr_rise && addr_q[7];
    // read of latched address, top bit zero
    wire par_rd = par_mode && !cs_f && !ale_f && !rd_f && !addr_q[7];

    // serial frame results, taken after the frame ends
    logic [7:0] bit_cnt_q;
    logic [23:0] rx_q;
    logic [4:0] crc_q;
    swah_fmt_t fmt_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fmt_q <= swah_fmt_plain8;
        end else begin
            fmt_q <= swah_fmt_t'({ms1_f, ms0_f});
        end
    end
    wire ser_end = ser_mode && cs_rise;
    wire chk_on = (fmt_q == swah_fmt_chk16) || (fmt_q == swah_fmt_chk24);
    wire [7:0] need = (fmt_q == swah_fmt_plain8) ? `SWAH_LEN8 :
        (fmt_q == swah_fmt_chk24) ? `SWAH_LEN24 : `SWAH_LEN16;
    wire cnt_bad = (bit_cnt_q[2:0] != 3'h0);
    wire crc_bad = chk_on && (crc_q != 5'h00);
    wire short_f = (bit_cnt_q < need);
    // frame content to address and data
    wire [7:0] ser_addr = (fmt_q == swah_fmt_addr16) ? rx_q[15:8] :
        (fmt_q == swah_fmt_chk24) ? rx_q[23:16] : `SWAH_ADDR_DRIVE_WR;
    wire [7:0] ser_data = (fmt_q == swah_fmt_plain8) ? rx_q[7:0] :
        (fmt_q == swah_fmt_addr16) ? rx_q[7:0] : rx_q[15:8];
    wire ser_wr = ser_end && !cnt_bad && !crc_bad && !short_f
        && ser_addr[7];

    // register write decode
    wire wr_any = par_wr || ser_wr;
    wire [6:0] wr_idx = par_wr ? addr_q[6:0] : ser_addr[6:0];
    wire [7:0] wr_data = par_wr ? bus_s : ser_data;
    wire wr_drive = wr_any && (wr_idx == `SWAH_IDX_DRIVE);
    wire wr_cfg = wr_any && (wr_idx == `SWAH_IDX_CONFIG);
    wire wr_lamp = wr_any && (wr_idx == `SWAH_IDX_LAMP);

    logic [7:0] drive_q;
    logic [2:0] cfg_q;
    logic [5:0] lamp_q;
    logic [7:0] chfault_q;
    logic chk_fail_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            drive_q <= '0;
        end else if (kill || soft_rst) begin
            drive_q <= '0;
        end else if (state_q == swah_direct) begin
            drive_q <= bus_s;
        end else if (wr_drive) begin
            drive_q <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= '0;
            lamp_q <= '0;
        end else if (soft_rst) begin
            cfg_q <= '0;
            lamp_q <= '0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= wr_data[2:0];
            end
            if (wr_lamp) begin
                lamp_q <= wr_data[5:0];
            end
        end
    end

    wire channel_fault_reg_take = !cfg_q[`SWAH_CFG_CHANNEL_FAULT_REG_SYNC] || sync_f;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chfault_q <= '0;
        end else if (channel_fault_reg_take) begin
            chfault_q <= chf_s;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chk_fail_q <= 1'b0;
        end else if (ser_end) begin
            chk_fail_q <= cnt_bad || crc_bad;
        end else if (soft_rst) begin
            chk_fail_q <= 1'b0;
        end
    end

    wire iso = cfg_q[`SWAH_CFG_ISO];
    wire stage_take = !iso || sync_f;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            switch_outputs <= '0;
        end else if (kill) begin
            switch_outputs <= '0;
        end else if (stage_take) begin
            switch_outputs <= drive_q;
        end
    end

    // read data select
    wire [6:0] rd_idx = addr_q[6:0];
    wire [7:0] status = {4'h0, serial_mode, chk_fail_q,
        in_s2_q[16], in_s2_q[17]};
    wire [7:0] rdata = (rd_idx == `SWAH_IDX_DRIVE) ? drive_q :
        (rd_idx == `SWAH_IDX_CONFIG) ? {5'h00, cfg_q} :
        (rd_idx == `SWAH_IDX_LAMP) ? {2'h0, lamp_q} :
        (rd_idx == `SWAH_IDX_FAULT) ? chfault_q :
        (rd_idx == `SWAH_IDX_STATUS) ? status : 8'h00;

    wire lamp_on = ser_mode && cfg_q[`SWAH_CFG_LAMP];
    wire [7:0] lamp_oe = {1'b0, lamp_q[0], 2'h0, lamp_q[1],
        lamp_q[2], lamp_q[5], 1'b0};

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mux_bus_out <= '0;
            mux_bus_oe <= '0;
            wr_n_oe <= 1'b0;
            ale_oe <= 1'b0;
        end else begin
            mux_bus_out <= par_rd ? rdata : 8'h00;
            mux_bus_oe <= par_rd ? 8'hff : (lamp_on ? lamp_oe : 8'h00);
            // column lines on strobe and latch pins
            wr_n_oe <= lamp_on && lamp_q[3];
            ale_oe <= lamp_on && lamp_q[4];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fault_n_out <= 1'b1;
            fault_n_oe <= 1'b0;
            check_fail_n <= 1'b1;
            check_fail_n_oe <= 1'b0;
            wr_n_out <= 1'b1;
            ale_out <= 1'b1;
            serial_mode <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            fault_n_out <= !fault_any;
            fault_n_oe <= fault_any;
            check_fail_n <= !chk_fail_q;
            check_fail_n_oe <= chk_fail_q;
            wr_n_out <= !(lamp_on && lamp_q[3]);
            ale_out <= !(lamp_on && lamp_q[4]);
            serial_mode <= ser_mode;
            serial_out_oe <= ser_mode && !cs_f;
        end
    end

    // shift clock domain
    logic armed_q;
    logic m1_s1_q;
    logic m1_s2_q;
    wire crc_restart = armed_q || (m1_s2_q && bit_cnt_q[3:0] == 4'h0);

    // frame start marker, set by chip select high
    always_ff @(posedge shift_clk or posedge cs_n or negedge rstn) begin
        if (!rstn) begin
            armed_q <= 1'b1;
        end else if (cs_n) begin
            armed_q <= 1'b1;
        end else begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge shift_clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_q <= '0;
            rx_q <= '0;
            m1_s1_q <= 1'b0;
            m1_s2_q <= 1'b0;
        end else begin
            bit_cnt_q <= armed_q ? 8'h01 : bit_cnt_q + 8'h01;
            rx_q <= {rx_q[22:0], serial_in};
            m1_s1_q <= (fmt_q == swah_fmt_chk16);
            m1_s2_q <= m1_s1_q;
        end
    end

    swah_crc5 u_crc (
        .shift_clk(shift_clk),
        .rstn(rstn),
        .restart(crc_restart),
        .bit_in(serial_in),
        .crc(crc_q)
    );

    always_ff @(negedge shift_clk or negedge rstn) begin
        if (!rstn) begin
            serial_out <= 1'b0;
        end else begin
            serial_out <= m1_s2_q ? rx_q[15] : rx_q[7];
        end
    end
endmodule : swah_top
`default_nettype wire

// [core/swah_map.svh]
/*
 * timing counts, register indices and fields of the host port.
 * assumes a 200 MHz core clock.
 */
// Notes on behaviour
// - fault flag low on any supply, link, switch fault
// - kill input low clears outputs and drive register
// - select pin picks parallel or serial; start-up parallel
// - inputs accepted after stable for blanking time
// - iso mode: sync low freezes output stage
// - sync rising copies drive data to outputs
// - config bit picks channel fault latch timing
// - host transfers only while chip select low
// - chip select low, latch high 100 us resets
// - tied-off strobes give parallel direct mode
// - write strobe rising captures data, address top one
// - read strobe low returns data, address top zero
// - latch high takes address; strobes stay high
// - latch low: all cycles hit last address
// - format pins set length 8/16/24 and check
// - serial in on rising, out on falling edge
// - shifted bits set drive or address and data
// - check-fail low on check or count error
// - serial lamp enable turns six pins open-drain
// - format encodings 0..3; modes 1 and 3 checked
// - check code x5+x4+x2+1, preset all ones
// - shift count not multiple of eight is error
// - serial output released while chip select high
`ifndef SWAH_MAP_SVH
`define SWAH_MAP_SVH

`define SWAH_CLK_MHZ 200
`define SWAH_BLANK_FAST_NS 20
`define SWAH_BLANK_SLOW_NS 200
`define SWAH_BLANK_FAST_CYC ((`SWAH_BLANK_FAST_NS*`SWAH_CLK_MHZ+999)/1000)
`define SWAH_BLANK_SLOW_CYC ((`SWAH_BLANK_SLOW_NS*`SWAH_CLK_MHZ+999)/1000)
`define SWAH_KILL_MIN_US 5
`define SWAH_RST_HOLD_US 100
`define SWAH_RST_HOLD_CYC (`SWAH_RST_HOLD_US*`SWAH_CLK_MHZ)
`define SWAH_STARTUP_CYC 64
`define SWAH_DIRECT_CYC 16

`define SWAH_IDX_DRIVE 7'h00
`define SWAH_IDX_CONFIG 7'h01
`define SWAH_IDX_LAMP 7'h02
`define SWAH_IDX_FAULT 7'h03
`define SWAH_IDX_STATUS 7'h04
`define SWAH_ADDR_RST 8'h80
`define SWAH_ADDR_DRIVE_WR 8'h80

`define SWAH_CFG_ISO 0
`define SWAH_CFG_CHANNEL_FAULT_REG_SYNC 1
`define SWAH_CFG_LAMP 2

`define SWAH_CRC_POLY 5'h15
`define SWAH_CRC_INIT 5'h1f
`define SWAH_LEN8 8'h08
`define SWAH_LEN16 8'h10
`define SWAH_LEN24 8'h18

`endif

// [core/swah_pkg.sv]
/*
 * types of the switch array host interface.
 * assumes nothing beyond a sv compiler.
 */
package swah_pkg;
    typedef enum logic [1:0] {
        swah_start,
        swah_par,
        swah_direct,
        swah_ser
    } swah_state_t;

    typedef enum logic [1:0] {
        swah_fmt_plain8,
        swah_fmt_chk16,
        swah_fmt_addr16,
        swah_fmt_chk24
    } swah_fmt_t;
endpackage : swah_pkg

// [core/swah_blank.sv]
/*
 * two-flop synchroniser and blanking filter.
 * assumes an asynchronous pin.
 */
`timescale 1ns/1ps
`default_nettype none
module swah_blank #(
    parameter int unsigned CYC = 4,
    parameter logic INIT = 1'b0
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic pin,
    output logic level
);
    localparam int W = $clog2(CYC + 1);
    logic s1_q;
    logic s2_q;
    logic [W-1:0] cnt_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= INIT;
            s2_q <= INIT;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            level <= INIT;
        end else if (s2_q == level) begin
            cnt_q <= '0;
        end else if (cnt_q == W'(CYC - 1)) begin
            cnt_q <= '0;
            level <= s2_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : swah_blank
`default_nettype wire

// [core/swah_crc5.sv]
/*
 * serial 5-bit check code, msb first.
 * assumes restart in the shift clock domain.
 */
`include "swah_map.svh"
`timescale 1ns/1ps
`default_nettype none
module swah_crc5 (
    input wire logic shift_clk,
    input wire logic rstn,
    input wire logic restart,
    input wire logic bit_in,
    output logic [4:0] crc
);
    logic [4:0] base;
    logic fb;

    assign base = restart ? `SWAH_CRC_INIT : crc;
    assign fb = base[4] ^ bit_in;

    always_ff @(posedge shift_clk or negedge rstn) begin
        if (!rstn) begin
            crc <= `SWAH_CRC_INIT;
        end else begin
            crc <= {base[3:0], 1'b0} ^ (fb ? `SWAH_CRC_POLY : 5'h00);
        end
    end
endmodule : swah_crc5
`default_nettype wire

// [tb/swah_top_assertions.sv]
/* checker of the swah_top pins.
   assumes a bind into swah_top, one core clock domain. */
`timescale 1ns/1ps
`default_nettype none
module swah_top_assertions (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic output_kill_n,
    input wire logic supply_fault,
    input wire logic link_fault,
    input wire logic [7:0] chan_fault,
    input wire logic [7:0] switch_outputs,
    input wire logic [7:0] mux_bus_oe,
    input wire logic wr_n_out,
    input wire logic wr_n_oe,
    input wire logic ale_out,
    input wire logic ale_oe,
    input wire logic serial_out_oe,
    input wire logic fault_n_out,
    input wire logic fault_n_oe,
    input wire logic check_fail_n,
    input wire logic check_fail_n_oe,
    input wire logic serial_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [4:0] idle_q;
    logic [4:0] idle_d;
    wire fault_any = supply_fault | link_fault | (|chan_fault);
    // cycles with chip select high
    assign idle_d = !cs_n ? 5'h00 : (&idle_q) ? idle_q : idle_q + 5'h01;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) idle_q <= 5'h00;
        else idle_q <= idle_d;
    end
    sequence s_fault;
        fault_any [*6];
    endsequence
    sequence s_calm;
        !fault_any [*6];
    endsequence
    a_fault_set: assert property (s_fault |-> fault_n_oe)
        else $error("fault flag not driven");
    a_fault_clear: assert property (s_calm |-> !fault_n_oe)
        else $error("fault flag stuck");
    a_fault_od: assert property (!(fault_n_oe && fault_n_out))
        else $error("fault flag drives high");
    a_check_od: assert property (!(check_fail_n_oe && check_fail_n))
        else $error("check flag drives high");
    a_kill_off: assert property (
        !output_kill_n [*5] |-> switch_outputs == 8'h00)
        else $error("outputs on during kill");
    a_bus_idle: assert property (
        idle_q > 5'h0f && !serial_mode |-> mux_bus_oe == 8'h00)
        else $error("bus driven while deselected");
    a_sdo_off: assert property (idle_q > 5'h09 |-> !serial_out_oe)
        else $error("serial out driven while deselected");
    a_start_par: assert property ($rose(rstn) |-> !serial_mode [*8])
        else $error("serial mode during start-up");
    a_reset_flags: assert property (
        $rose(rstn) |-> fault_n_out && check_fail_n)
        else $error("flag low after reset");
    a_lamp_od: assert property (
        !(wr_n_oe && wr_n_out) && !(ale_oe && ale_out))
        else $error("lamp pin drives high");
    a_lamp_ser: assert property (
        (wr_n_oe || ale_oe) |-> serial_mode || $past(serial_mode))
        else $error("lamp pin outside serial mode");
endmodule : swah_top_assertions
bind swah_top swah_top_assertions i_swah_top_assertions (.*);
`default_nettype wire

// [tb/swah_host.sv]
/* host model driving the bus and shift port.
   assumes pin changes at falling mclk. */
`timescale 1ns/1ps
`default_nettype none
module swah_host (
    input wire logic mclk,
    input wire logic [7:0] bus_in,
    output logic cs_n,
    output logic wr_n,
    output logic rd_n,
    output logic ale,
    output logic [7:0] bus,
    output logic shift_clk,
    output logic serial_in,
    output logic serial_format_sel1
);
    initial begin
        {cs_n, wr_n, rd_n, ale} = 4'he;
        {shift_clk, serial_in, serial_format_sel1} = 3'h0;
        bus = 8'h00;
    end
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask : step
    task automatic latch(input logic [7:0] a);
        {cs_n, ale, bus} = {2'b01, a};
        step(12);
        ale = 1'b0;
        step(10);
    endtask : latch
    task automatic wr(input logic [7:0] d);
        bus = d;
        wr_n = 1'b0;
        step(8);
        wr_n = 1'b1;
        step(14);
        bus = ~d;
    endtask : wr
    task automatic rd(output logic [7:0] d);
        rd_n = 1'b0;
        step(12);
        d = bus_in;
        rd_n = 1'b1;
        step(14);
    endtask : rd
    task automatic fmt(input logic [1:0] m);
        cs_n = 1'b1;
        {serial_format_sel1, rd_n} = m;
        step(60);
    endtask : fmt
    task automatic frame(input logic [23:0] v, input int n);
        cs_n = 1'b0;
        step(8);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = v[i];
            #16.3 shift_clk = 1'b1;
            #32 shift_clk = 1'b0;
            #15.7;
        end
        step(4);
        cs_n = 1'b1;
        serial_in = 1'b0;
        step(20);
    endtask : frame
endmodule : swah_host
`default_nettype wire

// [tb/switch_array_host_interface_test.sv]
/* bench of swah_top driven by the host model.
   assumes the design files and swah_host compiled first. */
`timescale 1ns/1ps
`default_nettype none
module switch_array_host_interface_test;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic interface_sel = 1'b0;
    logic output_kill_n = 1'b1;
    logic output_sync = 1'b1;
    logic supply_fault = 1'b0;
    logic link_fault = 1'b0;
    logic [7:0] chan_fault = 8'h00;
    logic cs_n, wr_n, rd_n, ale, shift_clk, serial_in, fmt1;
    logic [7:0] host_bus, mux_bus, switch_outputs, mux_bus_out, mux_bus_oe;
    logic wr_n_out, wr_n_oe, ale_out, ale_oe, serial_out, serial_out_oe;
    logic fault_n_out, fault_n_oe, check_fail_n, check_fail_n_oe;
    logic serial_mode;
    logic [7:0] rd_data;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #2.5 mclk = ~mclk;
    assign mux_bus = (mux_bus_oe & mux_bus_out) | (~mux_bus_oe & host_bus);
    swah_host i_swah_host (
        .mclk, .bus_in(mux_bus), .cs_n, .wr_n, .rd_n, .ale, .bus(host_bus),
        .shift_clk, .serial_in, .serial_format_sel1(fmt1)
    );
    swah_top #(.RST_HOLD_CYC(50), .STARTUP_CYC(8)) i_swah_top (
        .mclk, .rstn, .shift_clk, .serial_in, .interface_sel,
        .output_kill_n, .output_sync, .cs_n, .wr_n, .rd_n, .ale,
        .serial_format_sel1(fmt1), .mux_bus, .supply_fault, .link_fault,
        .chan_fault, .switch_outputs, .mux_bus_out, .mux_bus_oe, .wr_n_out,
        .wr_n_oe, .ale_out, .ale_oe, .serial_out, .serial_out_oe,
        .fault_n_out, .fault_n_oe, .check_fail_n, .check_fail_n_oe,
        .serial_mode
    );
    task automatic report_and_stop();
        $display("checks %0d wrong %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    function automatic logic [4:0] crc5(input logic [18:0] v, input int n);
        logic [4:0] c;
        c = 5'h1f;
        for (int i = n - 1; i >= 0; i--)
            c = {c[3:0], 1'b0} ^ ({5{c[4] ^ v[i]}} & 5'h15);
        return c;
    endfunction : crc5
    function automatic logic [23:0] f3(input logic [7:0] a, d);
        return {a, d, 3'h0, crc5({a, d, 3'h0}, 19)};
    endfunction : f3
    task automatic t_par();
        i_swah_host.latch(8'h80);
        i_swah_host.wr(8'h5a);
        chk("drive", switch_outputs, 8'h5a);
        i_swah_host.wr(8'ha5);
        chk("same addr", switch_outputs, 8'ha5);
        i_swah_host.cs_n = 1'b1;
        i_swah_host.wr(8'h11);
        chk("cs high", switch_outputs, 8'ha5);
        i_swah_host.latch(8'h00);
        i_swah_host.wr(8'h33);
        chk("wr top 0", switch_outputs, 8'ha5);
        i_swah_host.rd(rd_data);
        chk("read", rd_data, 8'ha5);
        $display("t_par done");
    endtask : t_par
    task automatic t_kill();
        output_kill_n = 1'b0;
        i_swah_host.step(6);
        chk("kill out", switch_outputs, 8'h00);
        i_swah_host.step(994);
        output_kill_n = 1'b1;
        i_swah_host.step(10);
        i_swah_host.rd(rd_data);
        chk("kill drive", rd_data, 8'h00);
        $display("t_kill done");
    endtask : t_kill
    task automatic t_iso();
        i_swah_host.latch(8'h81);
        i_swah_host.wr(8'h01);
        output_sync = 1'b0;
        i_swah_host.latch(8'h80);
        i_swah_host.wr(8'h77);
        chk("frozen", switch_outputs, 8'h00);
        output_sync = 1'b1;
        i_swah_host.step(12);
        chk("sync rise", switch_outputs, 8'h77);
        $display("t_iso done");
    endtask : t_iso
    task automatic t_soft();
        i_swah_host.bus = 8'h80;
        i_swah_host.ale = 1'b1;
        i_swah_host.step(90);
        i_swah_host.ale = 1'b0;
        i_swah_host.step(30);
        chk("soft reset", switch_outputs, 8'h00);
        i_swah_host.wr(8'h42);
        chk("reset addr", switch_outputs, 8'h42);
        $display("t_soft done");
    endtask : t_soft
    task automatic t_fault();
        for (int i = 0; i < 3; i++) begin
            {supply_fault, link_fault} = 2'b10 >> i;
            chan_fault = (i == 2) ? 8'h10 : 8'h00;
            i_swah_host.step(8);
            chk("flag set", {fault_n_oe, fault_n_out}, 8'h02);
        end
        chan_fault = 8'h00;
        i_swah_host.step(8);
        chk("flag free", {fault_n_oe, fault_n_out}, 8'h01);
        $display("t_fault done");
    endtask : t_fault
    task automatic t_ser();
        interface_sel = 1'b1;
        i_swah_host.fmt(2'd0);
        chk("mode", serial_mode, 8'h01);
        i_swah_host.frame(24'h3c, 8);
        chk("mode0", switch_outputs, 8'h3c);
        i_swah_host.frame(24'h05, 7);
        chk("count err", check_fail_n, 8'h00);
        i_swah_host.fmt(2'd1);
        i_swah_host.frame({8'h96, 3'h0, crc5({8'h96, 3'h0}, 11)}, 16);
        chk("mode1", switch_outputs, 8'h96);
        chk("err clear", check_fail_n, 8'h01);
        chk("daisy out", serial_out, 8'h01);
        i_swah_host.fmt(2'd2);
        i_swah_host.frame({8'h81, 8'h04}, 16);
        i_swah_host.frame({8'h82, 8'h09}, 16);
        chk("lamp", {mux_bus_oe[6], wr_n_oe, ale_oe}, 8'h06);
        i_swah_host.fmt(2'd3);
        i_swah_host.frame(f3(8'h80, 8'h69), 24);
        chk("mode3", switch_outputs, 8'h69);
        i_swah_host.frame(f3(8'h80, 8'h11) ^ 24'h01, 24);
        chk("crc err", check_fail_n, 8'h00);
        chk("crc skip", switch_outputs, 8'h69);
        $display("t_ser done");
    endtask : t_ser
    initial begin
        i_swah_host.step(16);
        rstn = 1'b1;
        i_swah_host.step(100);
        t_par();
        t_kill();
        t_iso();
        t_soft();
        t_fault();
        t_ser();
        report_and_stop();
    end
endmodule : switch_array_host_interface_test
`default_nettype wire
